// ===== common/charger_fault_status_map.vh
`ifndef CHARGER_FAULT_STATUS_MAP_VH
`define CHARGER_FAULT_STATUS_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CFS_OFF_FAULT        8'h09
`define CFS_OFF_STATUS       8'h0a
`define CFS_OFF_IDENT        8'h0b

// ----------------------------------------
// Fault register fields
// ----------------------------------------
`define CFS_FLT_WDOG_BIT     7
`define CFS_FLT_BOOST_BIT    6
`define CFS_FLT_CHG_HI       5
`define CFS_FLT_CHG_LO       4
`define CFS_FLT_BOVP_BIT     3
`define CFS_FLT_NTC_HI       2
`define CFS_FLT_NTC_LO       0

// ----------------------------------------
// Charge fault codes
// ----------------------------------------
`define CFS_CHG_NORMAL       2'h0
`define CFS_CHG_INPUT        2'h1
`define CFS_CHG_THERMAL      2'h2
`define CFS_CHG_TIMER        2'h3

// ----------------------------------------
// Thermistor zone codes
// ----------------------------------------
`define CFS_NTC_NORMAL       3'h0
`define CFS_NTC_WARM         3'h2
`define CFS_NTC_COOL         3'h3
`define CFS_NTC_COLD         3'h5
`define CFS_NTC_HOT          3'h6

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define CFS_ST_ATTACH_BIT    7
`define CFS_ST_VLIM_BIT      6
`define CFS_ST_ILIM_BIT      5
`define CFS_ST_TOPOFF_BIT    3
`define CFS_ST_INPUT_OVERVOLTAGE_STATE_BIT      2
`define CFS_ST_VMASK_BIT     1
`define CFS_ST_IMASK_BIT     0
`define CFS_MASK_RESET       1'b0

// ----------------------------------------
// Identity register fields
// ----------------------------------------
`define CFS_ID_RST_BIT       7
`define CFS_ID_PART_HI       6
`define CFS_ID_PART_LO       3
`define CFS_ID_REV_HI        1
`define CFS_ID_REV_LO        0

// ----------------------------------------
// Restore sequence length in cycles
// ----------------------------------------
`define CFS_RESTORE_CYCLES   4

`endif

// ===== hw/cfs_pulse_gate.v
`timescale 1ns/10ps
module cfs_pulse_gate
(
  // Clock and reset
  input  wire i_clk_sys,
  input  wire i_rst_n,
  // Loop level and mask
  input  wire i_level,
  input  wire i_mask,
  // Event pulse
  output reg  o_pulse
);

  reg level_d_ff;

  // ----------------------------------------
  // Rising edge of a loop entry, gated
  // ----------------------------------------
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      level_d_ff <= 1'b0;
      o_pulse    <= 1'b0;
    end
    else
    begin
      level_d_ff <= i_level;
      o_pulse    <= i_level & ~level_d_ff & ~i_mask;
    end
  end

endmodule

// ===== hw/charger_fault_status_regs.v
// Operation
// RULE1: Fault bit 7 reports watchdog expiry
// RULE2: Fault bit 6 reports boost cannot run
// RULE3: Bits 5:4 hold two-bit charge fault code
// RULE4: Input fault: overvoltage or low bus
// RULE5: Fault bit 3 reports battery overvoltage
// RULE6: Buck mode thermistor zone five codes
// RULE7: Boost mode zone limited to three codes
// RULE8: Status bit 7 shows input attached
// RULE9: Bits 6,5 show voltage/current limit loops
// RULE10: Status bit 3 shows top-off counting
// RULE11: Status bit 2 shows input overvoltage
// RULE12: Mask bit 1 suppresses voltage pulse
// RULE13: Mask bit 0 suppresses current pulse
// RULE14: Restore bit resets registers and timer
// RULE15: Restore bit self-clears when finished
// RULE16: Read-only part and revision codes
// RULE17: Writes to read-only bits ignored
`timescale 1ns/10ps
`include "charger_fault_status_map.vh"
module charger_fault_status_regs
#(
  parameter [3:0] PART_CODE     = 4'h5,  // Arbitrary value
  parameter [1:0] REVISION_CODE = 2'h1   // Arbitrary value
)
(
  // Clock and reset
  input  wire       i_clk_sys,
  input  wire       i_rst_n,
  // Register port
  input  wire [7:0] i_reg_addr,
  input  wire       i_reg_wr,
  input  wire [7:0] i_reg_wdata,
  output reg  [7:0] o_reg_rdata,
  // Fault conditions
  input  wire       i_watchdog_expired,
  input  wire       i_otg_overload,
  input  wire       i_bus_overvoltage,
  input  wire       i_battery_too_low,
  input  wire       i_input_sense_ovp,
  input  wire       i_bus_above_battery,
  input  wire       i_bus_below_min,
  input  wire       i_thermal_shutdown,
  input  wire       i_safety_timer_expired,
  input  wire       i_battery_overvoltage,
  input  wire       i_boost_mode,
  input  wire [2:0] i_thermistor_zone,
  // Status conditions
  input  wire       i_input_attached,
  input  wire       i_input_voltage_limit_loop,
  input  wire       i_input_current_limit_loop,
  input  wire       i_topoff_counting,
  input  wire       i_input_overvoltage_state,
  // Pulses and restore
  output wire       o_voltage_limit_pulse,
  output wire       o_current_limit_pulse,
  output reg        o_restore_defaults,
  output reg        o_safety_timer_restart
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam NSYNC = 18;
  wire [NSYNC-1:0] raw_in = {i_watchdog_expired, i_otg_overload, i_bus_overvoltage,
                             i_battery_too_low, i_input_sense_ovp, i_bus_above_battery,
                             i_bus_below_min, i_thermal_shutdown, i_safety_timer_expired,
                             i_battery_overvoltage, i_boost_mode, i_thermistor_zone,
                             i_input_attached, i_input_voltage_limit_loop,
                             i_input_current_limit_loop, i_topoff_counting};
  reg  [NSYNC-1:0] sync1_ff;
  reg  [NSYNC-1:0] sync2_ff;
  reg              acov1_ff;
  reg              acov2_ff;

  // Analog conditions are asynchronous to the register clock
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_ff <= {NSYNC{1'b0}};
      sync2_ff <= {NSYNC{1'b0}};
      acov1_ff <= 1'b0;
      acov2_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
      acov1_ff <= i_input_overvoltage_state;
      acov2_ff <= acov1_ff;
    end
  end

  wire       s_wdog     = sync2_ff[17];
  wire       s_otg_ol   = sync2_ff[16];
  wire       s_bus_ovp  = sync2_ff[15];
  wire       s_bat_low  = sync2_ff[14];
  wire       s_vac_ovp  = sync2_ff[13];
  wire       s_bus_gtb  = sync2_ff[12];
  wire       s_bus_lmin = sync2_ff[11];
  wire       s_tshut    = sync2_ff[10];
  wire       s_tmr_exp  = sync2_ff[9];
  wire       s_bovp     = sync2_ff[8];
  wire       s_boost    = sync2_ff[7];
  wire [2:0] s_zone     = sync2_ff[6:4];
  wire       s_attach   = sync2_ff[3];
  wire       s_vlim     = sync2_ff[2];
  wire       s_ilim     = sync2_ff[1];
  wire       s_topoff   = sync2_ff[0];

  // ----------------------------------------
  // Fault register content
  // ----------------------------------------
  reg  [1:0] charge_fault_code;
  reg  [2:0] thermistor_zone_code;
  wire       input_fault = s_vac_ovp | (s_bus_gtb & s_bus_lmin); // RULE4
  wire       boost_fault = s_otg_ol | s_bus_ovp | s_bat_low;       // RULE2

  // Thermal shutdown outranks the input and timer faults
  always @*
  begin
    if (s_tshut)
      charge_fault_code = `CFS_CHG_THERMAL;  // RULE3
    else if (input_fault)
      charge_fault_code = `CFS_CHG_INPUT;    // RULE3
    else if (s_tmr_exp)
      charge_fault_code = `CFS_CHG_TIMER;    // RULE3
    else
      charge_fault_code = `CFS_CHG_NORMAL;   // RULE3
  end

  // Unknown zone codes collapse to normal
  always @*
  begin
    case (s_zone)
      `CFS_NTC_COLD:
        thermistor_zone_code = `CFS_NTC_COLD;
      `CFS_NTC_HOT:
        thermistor_zone_code = `CFS_NTC_HOT;
      `CFS_NTC_WARM:
        thermistor_zone_code = s_boost ? `CFS_NTC_NORMAL : `CFS_NTC_WARM; // RULE6 RULE7
      `CFS_NTC_COOL:
        thermistor_zone_code = s_boost ? `CFS_NTC_NORMAL : `CFS_NTC_COOL; // RULE6 RULE7
      default:
        thermistor_zone_code = `CFS_NTC_NORMAL;
    endcase
  end

  wire [7:0] fault_report;
  assign fault_report[`CFS_FLT_WDOG_BIT]                  = s_wdog;            // RULE1
  assign fault_report[`CFS_FLT_BOOST_BIT]                 = boost_fault;       // RULE2
  assign fault_report[`CFS_FLT_CHG_HI:`CFS_FLT_CHG_LO]    = charge_fault_code; // RULE3
  assign fault_report[`CFS_FLT_BOVP_BIT]                  = s_bovp;            // RULE5
  assign fault_report[`CFS_FLT_NTC_HI:`CFS_FLT_NTC_LO]    = thermistor_zone_code;

  // ----------------------------------------
  // Masks and restore sequence
  // ----------------------------------------
  localparam ST_IDLE    = 2'b01;
  localparam ST_RESTORE = 2'b10;

  reg  [1:0] state_ff;
  reg  [1:0] nxt_state;
  reg  [2:0] cnt_ff;
  reg  [2:0] nxt_cnt;
  reg        vmask_ff;
  reg        imask_ff;
  reg        restore_bit_ff;

  wire wr_status = i_reg_wr & (i_reg_addr == `CFS_OFF_STATUS);
  wire wr_ident  = i_reg_wr & (i_reg_addr == `CFS_OFF_IDENT);
  wire start_rst = wr_ident & i_reg_wdata[`CFS_ID_RST_BIT] & state_ff[0]; // RULE14

  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (start_rst)
        begin
          nxt_state = ST_RESTORE;
          nxt_cnt   = 3'h0;
        end
      end
      ST_RESTORE:
      begin
        if (cnt_ff == `CFS_RESTORE_CYCLES - 1)
          nxt_state = ST_IDLE; // RULE15
        else
          nxt_cnt = cnt_ff + 3'h1;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_ff               <= ST_IDLE;
      cnt_ff                 <= 3'h0;
      vmask_ff               <= `CFS_MASK_RESET;
      imask_ff               <= `CFS_MASK_RESET;
      restore_bit_ff         <= 1'b0;
      o_restore_defaults     <= 1'b0;
      o_safety_timer_restart <= 1'b0;
    end
    else
    begin
      state_ff               <= nxt_state;
      cnt_ff                 <= nxt_cnt;
      restore_bit_ff         <= (nxt_state == ST_RESTORE);     // RULE15
      o_restore_defaults     <= (nxt_state == ST_RESTORE);     // RULE14
      o_safety_timer_restart <= start_rst;                     // RULE14
      if (state_ff == ST_RESTORE)
      begin
        vmask_ff <= `CFS_MASK_RESET; // RULE14
        imask_ff <= `CFS_MASK_RESET; // RULE14
      end
      else if (wr_status)
      begin
        // Only the mask bits take a write
        vmask_ff <= i_reg_wdata[`CFS_ST_VMASK_BIT]; // RULE17
        imask_ff <= i_reg_wdata[`CFS_ST_IMASK_BIT]; // RULE17
      end
    end
  end

  // ----------------------------------------
  // Event pulses
  // ----------------------------------------
  cfs_pulse_gate u_vlim_pulse
  (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_level   (s_vlim),
    .i_mask    (vmask_ff), // RULE12
    .o_pulse   (o_voltage_limit_pulse)
  );

  cfs_pulse_gate u_ilim_pulse
  (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_level   (s_ilim),
    .i_mask    (imask_ff), // RULE13
    .o_pulse   (o_current_limit_pulse)
  );

  // ----------------------------------------
  // Status and identity content
  // ----------------------------------------
  wire [7:0] status_reg;
  assign status_reg[`CFS_ST_ATTACH_BIT] = s_attach; // RULE8
  assign status_reg[`CFS_ST_VLIM_BIT]   = s_vlim;   // RULE9
  assign status_reg[`CFS_ST_ILIM_BIT]   = s_ilim;   // RULE9
  assign status_reg[4]                  = 1'b0;
  assign status_reg[`CFS_ST_TOPOFF_BIT] = s_topoff; // RULE10
  assign status_reg[`CFS_ST_INPUT_OVERVOLTAGE_STATE_BIT]   = acov2_ff; // RULE11
  assign status_reg[`CFS_ST_VMASK_BIT]  = vmask_ff;
  assign status_reg[`CFS_ST_IMASK_BIT]  = imask_ff;

  wire [7:0] ident_reg;
  assign ident_reg[`CFS_ID_RST_BIT]                  = restore_bit_ff;
  assign ident_reg[`CFS_ID_PART_HI:`CFS_ID_PART_LO]  = PART_CODE;     // RULE16
  assign ident_reg[2]                                = 1'b0;
  assign ident_reg[`CFS_ID_REV_HI:`CFS_ID_REV_LO]    = REVISION_CODE; // RULE16

  // ----------------------------------------
  // Read data register
  // ----------------------------------------
  // Registered read keeps the data output glitch free
  always @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_reg_rdata <= 8'h00;
    else
    begin
      case (i_reg_addr)
        `CFS_OFF_FAULT:  o_reg_rdata <= fault_report; // RULE17
        `CFS_OFF_STATUS: o_reg_rdata <= status_reg;
        `CFS_OFF_IDENT:  o_reg_rdata <= ident_reg;
        default:         o_reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// ===== tb/charger_fault_status_regs_asserts.sv
`timescale 1ns/10ps
module charger_fault_status_regs_chk
(
  // Clock and reset
  input wire       i_clk_sys,
  input wire       i_rst_n,
  // Register port
  input wire [7:0] i_reg_addr,
  input wire       i_reg_wr,
  input wire [7:0] i_reg_wdata,
  input wire [7:0] o_reg_rdata,
  // Loops, pulses and restore
  input wire       i_input_voltage_limit_loop,
  input wire       i_input_current_limit_loop,
  input wire       o_voltage_limit_pulse,
  input wire       o_current_limit_pulse,
  input wire       o_restore_defaults,
  input wire       o_safety_timer_restart
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  // ----------------------------------------
  // Mask shadow
  // ----------------------------------------
  // Clears in the same cycle as the DUT masks on restore; bench keeps loops quiet then
  reg [1:0] mask_ff;
  always @(posedge i_clk_sys or negedge i_rst_n)
    if (!i_rst_n)
      mask_ff <= 2'h0;
    else if (o_restore_defaults)
      mask_ff <= 2'h0;
    else if (i_reg_wr && i_reg_addr == 8'h0a)
      mask_ff <= i_reg_wdata[1:0];

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_restore_start;
    i_reg_wr && i_reg_addr == 8'h0b && i_reg_wdata[7] && !o_restore_defaults |=> o_restore_defaults && o_safety_timer_restart;
  endproperty
  a_restore_start: assert property (p_restore_start) else $error("restore did not start");
  property p_timer_once;
    o_safety_timer_restart |-> $rose(o_restore_defaults) ##1 !o_safety_timer_restart;
  endproperty
  a_timer_once: assert property (p_timer_once) else $error("timer restart pulse wrong");
  property p_restore_len;
    $rose(o_restore_defaults) |-> o_restore_defaults [*4] ##1 !o_restore_defaults;
  endproperty
  a_restore_len: assert property (p_restore_len) else $error("restore length wrong");
  property p_vpulse;
    $rose(i_input_voltage_limit_loop) && !mask_ff[1] |-> ##3 o_voltage_limit_pulse ##1 !o_voltage_limit_pulse;
  endproperty
  a_vpulse: assert property (p_vpulse) else $error("voltage pulse missing");
  property p_vmask;
    $rose(i_input_voltage_limit_loop) && mask_ff[1] |-> ##3 !o_voltage_limit_pulse;
  endproperty
  a_vmask: assert property (p_vmask) else $error("voltage pulse not masked");
  property p_ipulse;
    $rose(i_input_current_limit_loop) && !mask_ff[0] |-> ##3 o_current_limit_pulse ##1 !o_current_limit_pulse;
  endproperty
  a_ipulse: assert property (p_ipulse) else $error("current pulse missing");
  property p_imask;
    $rose(i_input_current_limit_loop) && mask_ff[0] |-> ##3 !o_current_limit_pulse;
  endproperty
  a_imask: assert property (p_imask) else $error("current pulse not masked");
  property p_unmapped;
    (i_reg_addr < 8'h09 || i_reg_addr > 8'h0b) |=> o_reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

bind charger_fault_status_regs charger_fault_status_regs_chk i_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .i_input_voltage_limit_loop(i_input_voltage_limit_loop), .i_input_current_limit_loop(i_input_current_limit_loop),
  .o_voltage_limit_pulse(o_voltage_limit_pulse), .o_current_limit_pulse(o_current_limit_pulse),
  .o_restore_defaults(o_restore_defaults), .o_safety_timer_restart(o_safety_timer_restart));

// ===== tb/test_charger_fault_status_regs.sv
`timescale 1ns/10ps
module test_charger_fault_status_regs;
  reg        i_clk_sys   = 1'b0;
  reg        i_rst_n     = 1'b0;
  reg [7:0]  i_reg_addr  = 8'h00;
  reg        i_reg_wr    = 1'b0;
  reg [7:0]  i_reg_wdata = 8'h00;
  reg [18:0] cond        = 19'h0;
  reg [7:0]  rd_data;
  wire [7:0] o_reg_rdata;
  wire       vpls;
  wire       ipls;
  wire       rst_dflt;
  wire       tmr_rst;
  integer    failures = 0;
  integer    n_checks = 0;
  integer    cyc = 0;
  integer    vcnt = 0;
  integer    icnt = 0;
  integer    tcnt = 0;
  localparam [7:0] IDENT = 8'h52;

  always #20 i_clk_sys = ~i_clk_sys;

  // ----------------------------------------
  // Design
  // ----------------------------------------
  charger_fault_status_regs #(.PART_CODE(4'ha), .REVISION_CODE(2'h2)) i_dut (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_watchdog_expired(cond[0]),
    .i_otg_overload(cond[1]), .i_bus_overvoltage(cond[2]), .i_battery_too_low(cond[3]),
    .i_input_sense_ovp(cond[4]), .i_bus_above_battery(cond[5]), .i_bus_below_min(cond[6]),
    .i_thermal_shutdown(cond[7]), .i_safety_timer_expired(cond[8]), .i_battery_overvoltage(cond[9]),
    .i_boost_mode(cond[10]), .i_thermistor_zone(cond[13:11]), .i_input_attached(cond[14]),
    .i_input_voltage_limit_loop(cond[15]), .i_input_current_limit_loop(cond[16]),
    .i_topoff_counting(cond[17]), .i_input_overvoltage_state(cond[18]),
    .o_voltage_limit_pulse(vpls), .o_current_limit_pulse(ipls),
    .o_restore_defaults(rst_dflt), .o_safety_timer_restart(tmr_rst));

  // ----------------------------------------
  // Pulse counting and timeout
  // ----------------------------------------
  // Counted on the falling edge, clear of the launch edge
  always @(negedge i_clk_sys)
  begin
    cyc = cyc + 1;
    if (vpls === 1'b1) vcnt = vcnt + 1;
    if (ipls === 1'b1) icnt = icnt + 1;
    if (tmr_rst === 1'b1) tcnt = tcnt + 1;
    if (cyc == 3000)
    begin
      failures = failures + 1;
      stop_test;
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input [7:0] seen, input [7:0] exp, input string what);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("unexpected %0s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    @(posedge i_clk_sys) #1;
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(posedge i_clk_sys) #1;
    i_reg_wr = 1'b0;
  endtask

  task chk_rd(input [7:0] a, input [7:0] e);
    @(posedge i_clk_sys) #1;
    i_reg_addr = a;
    @(posedge i_clk_sys) #1;
    check(o_reg_rdata, e, "register");
  endtask

  // Inputs cross two flops, so four cycles of settling
  task chk_cond(input [18:0] c, input [7:0] a, input [7:0] e);
    @(posedge i_clk_sys) #1;
    cond = c;
    repeat (4) @(posedge i_clk_sys);
    chk_rd(a, e);
  endtask

  task stop_test;
    $display("%0d checks, %0d failures", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge i_clk_sys);
    #1 i_rst_n = 1'b1;
    chk_rd(8'h0a, 8'h00);
    chk_rd(8'h0b, IDENT);
    chk_cond(19'h00001, 8'h09, 8'h80);
    chk_cond(19'h00002, 8'h09, 8'h40);
    chk_cond(19'h00004, 8'h09, 8'h40);
    chk_cond(19'h00008, 8'h09, 8'h40);
    chk_cond(19'h00010, 8'h09, 8'h10);
    chk_cond(19'h00060, 8'h09, 8'h10);
    chk_cond(19'h00020, 8'h09, 8'h00);
    chk_cond(19'h00040, 8'h09, 8'h00);
    chk_cond(19'h00080, 8'h09, 8'h20);
    chk_cond(19'h00100, 8'h09, 8'h30);
    chk_cond(19'h00090, 8'h09, 8'h20);
    chk_cond(19'h00200, 8'h09, 8'h08);
    chk_cond(19'h01000, 8'h09, 8'h02);
    chk_cond(19'h01800, 8'h09, 8'h03);
    chk_cond(19'h02800, 8'h09, 8'h05);
    chk_cond(19'h03000, 8'h09, 8'h06);
    chk_cond(19'h01400, 8'h09, 8'h00);
    chk_cond(19'h01c00, 8'h09, 8'h00);
    chk_cond(19'h02c00, 8'h09, 8'h05);
    chk_cond(19'h03400, 8'h09, 8'h06);
    chk_cond(19'h04000, 8'h0a, 8'h80);
    chk_cond(19'h08000, 8'h0a, 8'h40);
    chk_cond(19'h10000, 8'h0a, 8'h20);
    chk_cond(19'h20000, 8'h0a, 8'h08);
    chk_cond(19'h40000, 8'h0a, 8'h04);
    chk_cond(19'h00000, 8'h0a, 8'h00);
    check(vcnt[7:0], 8'h01, "voltage pulses");
    check(icnt[7:0], 8'h01, "current pulses");
    wr(8'h09, 8'hff);
    chk_rd(8'h09, 8'h00);
    wr(8'h0a, 8'hff);
    chk_rd(8'h0a, 8'h03);
    wr(8'h0b, 8'h7f);
    chk_rd(8'h0b, IDENT);
    chk_rd(8'h08, 8'h00);
    chk_rd(8'h0c, 8'h00);
    chk_cond(19'h18000, 8'h0a, 8'h63);
    chk_cond(19'h00000, 8'h0a, 8'h03);
    check(vcnt[7:0], 8'h01, "masked voltage pulses");
    check(icnt[7:0], 8'h01, "masked current pulses");
    // Mid-run power-on reset clears both masks
    @(posedge i_clk_sys) #1 i_rst_n = 1'b0;
    @(posedge i_clk_sys) #1 i_rst_n = 1'b1;
    chk_rd(8'h0a, 8'h00);
    wr(8'h0a, 8'h03);
    wr(8'h0b, 8'h80);
    check({7'h0, rst_dflt}, 8'h01, "restore level");
    check({7'h0, tmr_rst}, 8'h01, "timer restart");
    // Second request lands mid-restore and must not stretch it
    wr(8'h0b, 8'h80);
    chk_rd(8'h0b, IDENT | 8'h80);
    chk_rd(8'h0b, IDENT);
    chk_rd(8'h0a, 8'h00);
    check(tcnt[7:0], 8'h01, "timer restarts");
    chk_cond(19'h08000, 8'h0a, 8'h40);
    check(vcnt[7:0], 8'h02, "voltage pulses after restore");
    stop_test;
  end
endmodule
